// ===== rtl/pwr_clk_event_regs.vh
// Register offsets, field positions, reset values and timing for the power-mode and clock-event block.
// Assumes a 32-bit APB with word-aligned byte addresses; included by its bare name.
`ifndef PWR_CLK_EVENT_REGS_VH
`define PWR_CLK_EVENT_REGS_VH
// ==========================================================================
// Register byte offsets.
`define OFS_POWER_MODE_CONTROL 6'h00
`define OFS_CHARGE_PUMP_TIMING 6'h04
`define OFS_POWER_EVENT_FLAGS 6'h08
`define OFS_POWER_EVENT_ENABLES 6'h0c
`define OFS_SYSTEM_CLOCK_CONTROL 6'h10
`define OFS_OSC_CONTROL 6'h14
`define OFS_SYSTEM_PROTECT_KEY 6'h18
// ==========================================================================
// Protect key and power-mode codes.
`define PROTECT_KEY 16'h0096
`define PMODE_AUTO 3'h0
`define PMODE_NORMAL 3'h2
`define PMODE_ECONOMY 3'h3
`define PMODE_SUPER_ECO 3'h5
// ==========================================================================
// Field positions.
`define SCLK_WAKE_EN_BIT 15
`define SCLK_WAKE_DIV_HI 13
`define SCLK_WAKE_DIV_LO 12
`define SCLK_WAKE_SRC_HI 9
`define SCLK_WAKE_SRC_LO 8
`define SCLK_ACT_DIV_HI 5
`define SCLK_ACT_DIV_LO 4
`define SCLK_ACT_SRC_HI 1
`define SCLK_ACT_SRC_LO 0
`define OSC_LS_EN_BIT 0
`define OSC_SD_EN_BIT 1
// Event flag bit positions.
`define EV_MODE_DONE 0
`define EV_INTERNAL_OSCILLATOR_STABLE 1
`define EV_LS_STABLE 2
`define EV_HS_STABLE 3
`define EV_LS_STOP 4
`define EV_TRIM_DONE 5
`define EV_COUNT 6
// ==========================================================================
// Reset values and clock-source codes.
`define RST_ZERO16 16'h0000
`define SRC_INTERNAL_OSC 2'h0
`define SRC_LOW_SPEED_OSC 2'h1
`define SRC_HIGH_SPEED_OSC 2'h2
`define SRC_EXTERNAL_CLK 2'h3
// Sleep-entry delay in microseconds, and the system clock rate in kHz.
`define SLEEP_DELAY_US 1000
`define PCLK_KHZ 25000
`endif

// ===== rtl/pump_clock_divider.v
// Charge-pump clock divider: divides the synchronised low-speed clock by 32, 64, 128 or 256.
// Assumes ls_clk_sync is already in the pclk domain; the output toggles on its rising edges.
`timescale 1ns/100ps
module pump_clock_divider
(
  input wire pclk,
  input wire presetn,
  input wire ls_clk_sync,
  input wire [1:0] div_sel,
  output reg pump_clk_r
);
  reg ls_prev_r;
  reg [6:0] cnt_r;
  wire ls_rise;
  wire [6:0] half_limit;
  // Half period in low-speed edges: 16 << div_sel, minus one.
  assign half_limit = (7'h10 << div_sel) - 7'h01;
  assign ls_rise = ls_clk_sync & ~ls_prev_r;
  // Count low-speed rising edges and toggle at each half period.
  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      ls_prev_r <= 1'b0;
      cnt_r <= 7'h00;
      pump_clk_r <= 1'b0;
    end
    else
    begin
      ls_prev_r <= ls_clk_sync;
      if (ls_rise)
      begin
        if (cnt_r >= half_limit)
        begin
          cnt_r <= 7'h00;
          pump_clk_r <= ~pump_clk_r;
        end
        else
        begin
          cnt_r <= cnt_r + 7'h01;
        end
      end
    end
  end
endmodule // pump_clock_divider

// ===== rtl/power_mode_clock_event_regs.v
// Power-generator mode control, charge-pump clock select, clock-event flags and system clock register.
// Assumes an APB master on pclk; oscillator status inputs are asynchronous and synchronised here.
//
// Notes on behaviour
// RULE1: Mode done on leaving super economy, or auto normal-to-economy.
// RULE2: Internal oscillator stabilised sets its flag.
// RULE3: Low-speed oscillator stabilised sets its flag.
// RULE4: High-speed oscillator stabilised sets its flag.
// RULE5: Low-speed stop or enable falling sets stop flag.
// RULE6: Trim completion sets trim-done flag.
// RULE7: Flags read pending; write one clears, zero ignored.
// RULE8: Interrupt only for set and enabled flags.
// RULE9: Mode done set only while low-speed oscillator runs.
// RULE10: Auto mode sleep entry sets mode done after 1ms.
// RULE11: Software disables mode-done interrupt before low-speed sleep.
// RULE12: Power mode codes decode; reset to automatic.
// RULE13: Reserved power mode writes store automatic.
// RULE14: Charge pump clock is low-speed divided 32..256.
// RULE15: Wake switching enable sits at bit fifteen.
// RULE16: Protected fields writable only after key 0x0096.
// RULE17: Wake with switching copies wake fields to active.
// RULE18: Clock source codes internal, low, high, external.
// RULE19: Simultaneous set and clear leaves flag set.
//
// The implementer's own choices: register access over APB and the placing of the registers.
`timescale 1ns/100ps
`include "pwr_clk_event_regs.vh"
module power_mode_clock_event_regs
#(
  parameter SLEEP_DELAY_CYCLES = ((`SLEEP_DELAY_US * `PCLK_KHZ) / 1000)
)
(
  input wire pclk,
  input wire presetn,
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [31:0] paddr,
  input wire [31:0] pwdata,
  output reg [31:0] prdata,
  output wire pready,
  output wire pslverr,
  input wire low_speed_clock,
  input wire low_speed_osc_running,
  input wire internal_oscillator_stable_done,
  input wire low_speed_stable_done,
  input wire high_speed_stable_done,
  input wire trim_done,
  input wire regulator_settled,
  input wire cpu_sleeping,
  input wire fast_clock_active,
  input wire wake_event,
  output wire [2:0] power_mode_field,
  output wire pump_clock,
  output wire [1:0] active_source,
  output wire [1:0] active_divider,
  output wire low_speed_osc_enable,
  output wire stop_detector_enable,
  output wire irq
);
  // ==========================================================================
  // Input synchronisers.
  localparam NSYNC = 10;
  reg [NSYNC-1:0] sync1_r;
  reg [NSYNC-1:0] sync2_r;
  reg [NSYNC-1:0] prev_r;
  wire [NSYNC-1:0] async_in;
  wire [NSYNC-1:0] rise;
  assign async_in = {low_speed_clock, wake_event, fast_clock_active, cpu_sleeping, regulator_settled,
    trim_done, high_speed_stable_done, low_speed_stable_done, internal_oscillator_stable_done, low_speed_osc_running};
  // Two flops per pin, then a third stage used only for edge detection.
  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      sync1_r <= {NSYNC{1'b0}};
      sync2_r <= {NSYNC{1'b0}};
      prev_r <= {NSYNC{1'b0}};
    end
    else
    begin
      sync1_r <= async_in;
      sync2_r <= sync1_r;
      prev_r <= sync2_r;
    end
  end
  assign rise = sync2_r & ~prev_r;
  wire ls_running_s = sync2_r[0];
  wire regulator_settled_rise = rise[5];
  wire sleeping_s = sync2_r[6];
  wire sleep_entry = rise[6];
  wire fast_active_s = sync2_r[7];
  wire wake_rise = rise[8];
  wire ls_clk_s = sync2_r[9];
  // ==========================================================================
  // Registers.
  reg [2:0] pmode_r;
  reg [1:0] pump_div_r;
  reg [`EV_COUNT-1:0] flags_r;
  reg [`EV_COUNT-1:0] enables_r;
  reg wake_en_r;
  reg [1:0] wake_div_r;
  reg [1:0] wake_src_r;
  reg [1:0] act_div_r;
  reg [1:0] act_src_r;
  reg ls_en_r;
  reg sd_en_r;
  reg unlocked_r;
  reg [2:0] prev_mode_r;
  reg pending_r;
  reg [2:0] pend_from_r;
  reg [2:0] pend_to_r;
  reg sleep_timer_on_r;
  reg [31:0] sleep_cnt_r;
  reg fast_before_sleep_r;
  reg [`EV_COUNT-1:0] ev_set;
  // Decode power mode writes; reserved codes store automatic.
  function [2:0] decode_mode;
    input [2:0] code;
    begin
      case (code)
        `PMODE_NORMAL: decode_mode = `PMODE_NORMAL;
        `PMODE_ECONOMY: decode_mode = `PMODE_ECONOMY;
        `PMODE_SUPER_ECO: decode_mode = `PMODE_SUPER_ECO;
        default: decode_mode = `PMODE_AUTO; // RULE12 RULE13
      endcase
    end
  endfunction
  // ==========================================================================
  // APB decode: zero-wait, always ready, error on unmapped addresses.
  wire access = psel & penable;
  wire wr = access & pwrite;
  wire [5:0] addr = paddr[5:0];
  wire mapped = (paddr[31:6] == 26'h0) && (addr[1:0] == 2'h0) && (addr <= `OFS_SYSTEM_PROTECT_KEY);
  wire wr_ok = wr & mapped;
  wire wp_ok = wr_ok & unlocked_r; // RULE16
  assign pready = 1'b1;
  assign pslverr = access & ~mapped;
  // Automatic-mode track: the regulator itself decides; here normal is assumed before economy.
  wire ls_stop = sync2_r[0] == 1'b0 && prev_r[0] == 1'b1;
  // Event detection.
  always @*
  begin
    ev_set = {`EV_COUNT{1'b0}};
    ev_set[`EV_INTERNAL_OSCILLATOR_STABLE] = rise[1]; // RULE2
    ev_set[`EV_LS_STABLE] = rise[2]; // RULE3
    ev_set[`EV_HS_STABLE] = rise[3]; // RULE4
    ev_set[`EV_TRIM_DONE] = rise[4]; // RULE6
    ev_set[`EV_LS_STOP] = ls_stop |
      (wp_ok && addr == `OFS_OSC_CONTROL && ((ls_en_r & ~pwdata[`OSC_LS_EN_BIT]) |
      (sd_en_r & ~pwdata[`OSC_SD_EN_BIT]))); // RULE5
    ev_set[`EV_MODE_DONE] = ls_running_s & // RULE9
      ((pending_r && regulator_settled_rise &&
        ((pend_from_r == `PMODE_SUPER_ECO && pend_to_r != `PMODE_SUPER_ECO) || // RULE1
         (pend_to_r == `PMODE_AUTO && pend_from_r == `PMODE_NORMAL))) ||
       (sleep_timer_on_r && sleep_cnt_r == SLEEP_DELAY_CYCLES - 1)); // RULE10
  end
  // Flags: set wins over write-one clear.
  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      flags_r <= {`EV_COUNT{1'b0}};
    end
    else if (wr_ok && addr == `OFS_POWER_EVENT_FLAGS)
    begin
      flags_r <= (flags_r & ~pwdata[`EV_COUNT-1:0]) | ev_set; // RULE7 RULE19
    end
    else
    begin
      flags_r <= flags_r | ev_set;
    end
  end
  // Mode transition tracking and sleep-entry timer in automatic mode.
  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      prev_mode_r <= `PMODE_AUTO;
      pending_r <= 1'b0;
      pend_from_r <= `PMODE_AUTO;
      pend_to_r <= `PMODE_AUTO;
      sleep_timer_on_r <= 1'b0;
      sleep_cnt_r <= 32'h0;
      fast_before_sleep_r <= 1'b0;
    end
    else
    begin
      prev_mode_r <= pmode_r;
      fast_before_sleep_r <= fast_active_s;
      if (prev_mode_r != pmode_r)
      begin
        pending_r <= 1'b1;
        pend_from_r <= prev_mode_r;
        pend_to_r <= pmode_r;
      end
      else if (regulator_settled_rise)
      begin
        pending_r <= 1'b0;
      end
      if (pmode_r == `PMODE_AUTO && sleep_entry && fast_before_sleep_r)
      begin
        sleep_timer_on_r <= 1'b1; // RULE10
        sleep_cnt_r <= 32'h0;
      end
      else if (sleep_timer_on_r)
      begin
        if (!sleeping_s || sleep_cnt_r == SLEEP_DELAY_CYCLES - 1)
        begin
          sleep_timer_on_r <= 1'b0;
        end
        else
        begin
          sleep_cnt_r <= sleep_cnt_r + 32'h1;
        end
      end
    end
  end
  // ==========================================================================
  // Control register writes, protect key and wake-up reload.
  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      pmode_r <= `PMODE_AUTO;
      pump_div_r <= 2'h0;
      enables_r <= {`EV_COUNT{1'b0}};
      wake_en_r <= 1'b0;
      wake_div_r <= 2'h0;
      wake_src_r <= `SRC_INTERNAL_OSC;
      act_div_r <= 2'h0;
      act_src_r <= `SRC_INTERNAL_OSC; // RULE18
      ls_en_r <= 1'b0;
      sd_en_r <= 1'b0;
      unlocked_r <= 1'b0;
    end
    else
    begin
      if (wr_ok && addr == `OFS_SYSTEM_PROTECT_KEY)
      begin
        unlocked_r <= (pwdata[15:0] == `PROTECT_KEY); // RULE16
      end
      if (wr_ok && addr == `OFS_POWER_EVENT_ENABLES)
      begin
        enables_r <= pwdata[`EV_COUNT-1:0];
      end
      if (wp_ok && addr == `OFS_POWER_MODE_CONTROL)
      begin
        pmode_r <= decode_mode(pwdata[2:0]); // RULE12 RULE13
      end
      if (wp_ok && addr == `OFS_CHARGE_PUMP_TIMING)
      begin
        pump_div_r <= pwdata[1:0]; // RULE14
      end
      if (wp_ok && addr == `OFS_OSC_CONTROL)
      begin
        ls_en_r <= pwdata[`OSC_LS_EN_BIT];
        sd_en_r <= pwdata[`OSC_SD_EN_BIT];
      end
      if (wake_rise && wake_en_r)
      begin
        act_src_r <= wake_src_r; // RULE17
        act_div_r <= wake_div_r;
      end
      else if (wp_ok && addr == `OFS_SYSTEM_CLOCK_CONTROL)
      begin
        wake_en_r <= pwdata[`SCLK_WAKE_EN_BIT]; // RULE15
        wake_div_r <= pwdata[`SCLK_WAKE_DIV_HI:`SCLK_WAKE_DIV_LO];
        wake_src_r <= pwdata[`SCLK_WAKE_SRC_HI:`SCLK_WAKE_SRC_LO];
        act_div_r <= pwdata[`SCLK_ACT_DIV_HI:`SCLK_ACT_DIV_LO];
        act_src_r <= pwdata[`SCLK_ACT_SRC_HI:`SCLK_ACT_SRC_LO]; // RULE18
      end
    end
  end
  // ==========================================================================
  // Read data, registered on the setup cycle of a read.
  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      prdata <= 32'h0;
    end
    else if (psel && !penable && !pwrite)
    begin
      prdata <= 32'h0;
      case (addr)
        `OFS_POWER_MODE_CONTROL: prdata[2:0] <= pmode_r;
        `OFS_CHARGE_PUMP_TIMING: prdata[1:0] <= pump_div_r;
        `OFS_POWER_EVENT_FLAGS: prdata[`EV_COUNT-1:0] <= flags_r; // RULE7
        `OFS_POWER_EVENT_ENABLES: prdata[`EV_COUNT-1:0] <= enables_r;
        `OFS_SYSTEM_CLOCK_CONTROL:
        begin
          prdata[`SCLK_WAKE_EN_BIT] <= wake_en_r;
          prdata[`SCLK_WAKE_DIV_HI:`SCLK_WAKE_DIV_LO] <= wake_div_r;
          prdata[`SCLK_WAKE_SRC_HI:`SCLK_WAKE_SRC_LO] <= wake_src_r;
          prdata[`SCLK_ACT_DIV_HI:`SCLK_ACT_DIV_LO] <= act_div_r;
          prdata[`SCLK_ACT_SRC_HI:`SCLK_ACT_SRC_LO] <= act_src_r;
        end
        `OFS_OSC_CONTROL: prdata[1:0] <= {sd_en_r, ls_en_r};
        `OFS_SYSTEM_PROTECT_KEY: prdata[0] <= unlocked_r;
        default: prdata <= 32'h0;
      endcase
    end
  end
  // Charge-pump clock from the divided low-speed clock.
  pump_clock_divider u_pump_div
  (
    .pclk(pclk),
    .presetn(presetn),
    .ls_clk_sync(ls_clk_s),
    .div_sel(pump_div_r),
    .pump_clk_r(pump_clock)
  ); // RULE14
  // Outputs.
  assign irq = |(flags_r & enables_r); // RULE8
  assign power_mode_field = pmode_r;
  assign active_source = act_src_r;
  assign active_divider = act_div_r;
  assign low_speed_osc_enable = ls_en_r;
  assign stop_detector_enable = sd_en_r;
endmodule // power_mode_clock_event_regs

// ===== bench/osc_env.sv
// Partner model: oscillator, regulator and CPU sleep status lines.
// Assumes pclk from the bench; status lines change just after a rising edge.
`timescale 1ns/100ps
module osc_env
(
  input wire pclk,
  output reg low_speed_clock,
  output wire low_speed_osc_running,
  output wire internal_oscillator_stable_done,
  output wire low_speed_stable_done,
  output wire high_speed_stable_done,
  output wire trim_done,
  output wire regulator_settled,
  output wire cpu_sleeping,
  output wire fast_clock_active,
  output wire wake_event
);
  reg [8:0] ev_r;
  // ========
  // Status lines; a stabilised or finished event is a rising edge.
  assign regulator_settled = ev_r[0];
  assign internal_oscillator_stable_done = ev_r[1];
  assign low_speed_stable_done = ev_r[2];
  assign high_speed_stable_done = ev_r[3];
  assign low_speed_osc_running = ev_r[4];
  assign trim_done = ev_r[5];
  assign cpu_sleeping = ev_r[6];
  assign fast_clock_active = ev_r[7];
  assign wake_event = ev_r[8];
  // The low-speed oscillator runs free, unrelated to pclk.
  initial
  begin
    ev_r = 9'h000;
    low_speed_clock = 1'b0;
    forever #130 low_speed_clock = ~low_speed_clock;
  end
  // Sets one line, then holds it long enough to pass the synchroniser.
  task drive(input integer idx, input reg val);
  begin
    @(posedge pclk);
    ev_r[idx] <= val;
    repeat (4) @(posedge pclk);
  end
  endtask
endmodule // osc_env

// ===== bench/pwr_evt_chk.sv
// Checker for the power-mode and clock-event block.
// Assumes it is bound to power_mode_clock_event_regs and sees only its ports.
`timescale 1ns/100ps
`include "pwr_clk_event_regs.vh"
module pwr_evt_chk
(
  input wire pclk,
  input wire presetn,
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [31:0] paddr,
  input wire [31:0] pwdata,
  input wire pready,
  input wire wake_event,
  input wire [2:0] power_mode_field,
  input wire [1:0] active_source,
  input wire [1:0] active_divider,
  input wire low_speed_osc_enable,
  input wire stop_detector_enable,
  input wire irq
);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  reg unl_r;
  reg [4:0] wk_r;
  wire wr = psel && penable && pwrite && pready;
  wire leg = pwdata[2:0] == 3'h0 || pwdata[2:0] == 3'h2 || pwdata[2:0] == 3'h3 || pwdata[2:0] == 3'h5;
  // Tracks the unlock state and the wake fields that software wrote.
  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      unl_r <= 1'b0;
      wk_r <= 5'h00;
    end
    else if (wr && paddr == `OFS_SYSTEM_PROTECT_KEY)
      unl_r <= pwdata[15:0] == `PROTECT_KEY;
    else if (wr && paddr == `OFS_SYSTEM_CLOCK_CONTROL && unl_r)
      wk_r <= {pwdata[15], pwdata[13:12], pwdata[9:8]};
  end
  // ========
  // Assertions.
  mode_legal_a: assert property (!(power_mode_field inside {3'h1, 3'h4, 3'h6, 3'h7}))
    else $error("power mode holds a reserved code");
  mode_write_a: assert property (wr && paddr == 0 && unl_r |=>
    power_mode_field == ($past(leg) ? $past(pwdata[2:0]) : 3'h0)) else $error("power mode write wrong");
  mode_lock_a: assert property (wr && paddr == 0 && !unl_r |=> $stable(power_mode_field))
    else $error("locked power mode changed");
  osc_write_a: assert property (wr && paddr == `OFS_OSC_CONTROL && unl_r |=>
    {stop_detector_enable, low_speed_osc_enable} == $past(pwdata[1:0])) else $error("osc enables wrong");
  wake_load_a: assert property ($rose(wake_event) && wk_r[4] |-> ##[2:4]
    (active_source == wk_r[1:0] && active_divider == wk_r[3:2])) else $error("wake reload missing");
  wake_keep_a: assert property ($rose(wake_event) && !wk_r[4] && !wr |=>
    ($stable(active_source) && $stable(active_divider)) [*4]) else $error("active fields changed on wake");
  src_write_a: assert property (wr && paddr == `OFS_SYSTEM_CLOCK_CONTROL && unl_r |=>
    active_source == $past(pwdata[1:0])) else $error("active source write wrong");
  irq_off_a: assert property (wr && paddr == `OFS_POWER_EVENT_ENABLES && pwdata[5:0] == 6'h00 |=> !irq)
    else $error("irq high with all enables off");
  irq_clear_a: assert property (wr && paddr == `OFS_POWER_EVENT_FLAGS && pwdata[5:0] == 6'h3f |=> !irq)
    else $error("irq high after all flags cleared");
  wake_c: cover property ($rose(wake_event) && wk_r[4]);
  mode_c: cover property (wr && paddr == 0 && unl_r && !leg);
  irq_c: cover property ($rose(irq));
endmodule // pwr_evt_chk
bind power_mode_clock_event_regs pwr_evt_chk chk (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
  .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready), .wake_event(wake_event),
  .power_mode_field(power_mode_field), .active_source(active_source), .active_divider(active_divider),
  .low_speed_osc_enable(low_speed_osc_enable), .stop_detector_enable(stop_detector_enable), .irq(irq));

// ===== bench/tb_top.sv
// Testbench for the power-mode and clock-event block.
// Assumes the osc_env partner and the bound checker; APB master tasks drive the registers.
`timescale 1ns/100ps
`include "pwr_clk_event_regs.vh"
`define CHK(n, e, g) begin total_checks++; if ((g) !== (e)) begin fail_count++; \
  $display("[ERR] %s expected %h seen %h", n, e, g); end end
module tb_top;
  reg pclk, presetn, psel, penable, pwrite;
  reg [31:0] paddr, pwdata, r;
  reg err;
  wire pslverr_w;
  wire [31:0] prdata;
  wire [2:0] pm;
  wire [1:0] asrc, adiv;
  wire pready, lsc, lsr, ios, lss, hss, trd, rgs, slp, fca, wke, irq;
  integer fail_count = 0, total_checks = 0, cyc = 0, i, b;
  osc_env env (.pclk(pclk), .low_speed_clock(lsc), .low_speed_osc_running(lsr), .internal_oscillator_stable_done(ios),
    .low_speed_stable_done(lss), .high_speed_stable_done(hss), .trim_done(trd), .regulator_settled(rgs),
    .cpu_sleeping(slp), .fast_clock_active(fca), .wake_event(wke));
  power_mode_clock_event_regs #(.SLEEP_DELAY_CYCLES(20)) dut (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr_w), .low_speed_clock(lsc), .low_speed_osc_running(lsr), .internal_oscillator_stable_done(ios),
    .low_speed_stable_done(lss), .high_speed_stable_done(hss), .trim_done(trd), .regulator_settled(rgs),
    .cpu_sleeping(slp), .fast_clock_active(fca), .wake_event(wke), .power_mode_field(pm), .pump_clock(),
    .active_source(asrc), .active_divider(adiv), .low_speed_osc_enable(), .stop_detector_enable(), .irq(irq));
  // ========
  // One APB transfer: setup, then access until pready is seen high.
  task apb(input reg w, input reg [31:0] a, input reg [31:0] d, output reg [31:0] q);
  begin
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1) @(posedge pclk);
    q = prdata;
    err = pslverr_w;
    psel <= 1'b0;
    penable <= 1'b0;
  end
  endtask
  // Prints the verdict and ends the run.
  task report_and_stop;
  begin
    if (fail_count == 0 && total_checks > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  end
  endtask
  // Clock and hang guard.
  initial
  begin
    pclk = 1'b0;
    forever #20 pclk = ~pclk;
  end
  always @(posedge pclk)
  begin
    cyc <= cyc + 1;
    if (cyc == 20000)
    begin
      fail_count++;
      report_and_stop;
    end
  end
  // ========
  // Main sequence.
  initial
  begin
    {presetn, psel, penable, pwrite, paddr, pwdata} = 0;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    for (i = 0; i < 20; i = i + 4)
    begin
      apb(0, i, 0, r);
      `CHK("reset value", 32'h0, r)
    end
    apb(1, `OFS_POWER_MODE_CONTROL, 5, r);
    apb(0, `OFS_POWER_MODE_CONTROL, 0, r);
    `CHK("locked mode", 32'h0, r)
    apb(0, 32'h1c, 0, r);
    `CHK("unmapped", 32'h0, r)
    `CHK("unmapped error", 1'b1, err)
    apb(1, `OFS_SYSTEM_PROTECT_KEY, `PROTECT_KEY, r);
    for (i = 0; i < 8; i = i + 1)
    begin
      apb(1, `OFS_POWER_MODE_CONTROL, i, r);
      apb(0, `OFS_POWER_MODE_CONTROL, 0, r);
      `CHK("mode code", (i == 2 || i == 3 || i == 5) ? i : 0, r)
      `CHK("mode pin", (i == 2 || i == 3 || i == 5) ? i : 0, pm)
      `CHK("mapped error", 1'b0, err)
    end
    apb(1, `OFS_CHARGE_PUMP_TIMING, 32'h7, r);
    apb(0, `OFS_CHARGE_PUMP_TIMING, 0, r);
    `CHK("pump div", 32'h3, r)
    env.drive(4, 1);
    env.drive(0, 1);
    env.drive(0, 0);
    apb(1, `OFS_POWER_EVENT_FLAGS, 32'h3f, r);
    for (i = 0; i < 4; i = i + 1)
    begin
      b = (i == 3) ? 5 : i + 1;
      env.drive(b, 1);
      env.drive(b, 0);
      apb(0, `OFS_POWER_EVENT_FLAGS, 0, r);
      `CHK("event flag", 32'h1 << b, r)
      apb(1, `OFS_POWER_EVENT_FLAGS, 0, r);
      apb(0, `OFS_POWER_EVENT_FLAGS, 0, r);
      `CHK("write zero", 32'h1 << b, r)
      apb(1, `OFS_POWER_EVENT_ENABLES, 32'h3f ^ (32'h1 << b), r);
      @(negedge pclk) `CHK("irq masked", 1'b0, irq)
      apb(1, `OFS_POWER_EVENT_ENABLES, 32'h1 << b, r);
      @(negedge pclk) `CHK("irq on", 1'b1, irq)
      apb(1, `OFS_POWER_EVENT_FLAGS, 32'h1 << b, r);
      apb(0, `OFS_POWER_EVENT_FLAGS, 0, r);
      `CHK("cleared", 32'h0, r)
    end
    apb(1, `OFS_POWER_EVENT_ENABLES, 0, r);
    env.drive(4, 0);
    env.drive(4, 1);
    apb(0, `OFS_POWER_EVENT_FLAGS, 0, r);
    `CHK("ls stop", 32'h10, r)
    apb(1, `OFS_POWER_EVENT_FLAGS, 32'h3f, r);
    apb(1, `OFS_OSC_CONTROL, 32'h3, r);
    apb(1, `OFS_OSC_CONTROL, 32'h1, r);
    apb(0, `OFS_POWER_EVENT_FLAGS, 0, r);
    `CHK("detector off", 32'h10, r)
    apb(1, `OFS_POWER_EVENT_FLAGS, 32'h3f, r);
    apb(1, `OFS_POWER_MODE_CONTROL, `PMODE_SUPER_ECO, r);
    env.drive(0, 1);
    env.drive(0, 0);
    apb(0, `OFS_POWER_EVENT_FLAGS, 0, r);
    `CHK("enter super eco", 32'h0, r)
    apb(1, `OFS_POWER_MODE_CONTROL, `PMODE_AUTO, r);
    env.drive(0, 1);
    env.drive(0, 0);
    apb(0, `OFS_POWER_EVENT_FLAGS, 0, r);
    `CHK("leave super eco", 32'h1, r)
    apb(1, `OFS_POWER_EVENT_FLAGS, 32'h3f, r);
    apb(1, `OFS_POWER_EVENT_ENABLES, 0, r);
    env.drive(7, 1);
    env.drive(6, 1);
    apb(0, `OFS_POWER_EVENT_FLAGS, 0, r);
    `CHK("sleep early", 32'h0, r)
    repeat (20) @(posedge pclk);
    apb(0, `OFS_POWER_EVENT_FLAGS, 0, r);
    `CHK("sleep delay", 32'h1, r)
    `CHK("no wake irq", 1'b0, irq)
    env.drive(6, 0);
    apb(1, `OFS_SYSTEM_CLOCK_CONTROL, 32'hb200, r);
    apb(0, `OFS_SYSTEM_CLOCK_CONTROL, 0, r);
    `CHK("wake enable", 32'hb200, r)
    env.drive(8, 1);
    apb(0, `OFS_SYSTEM_CLOCK_CONTROL, 0, r);
    `CHK("wake reload", 32'hb232, r)
    `CHK("high speed src", `SRC_HIGH_SPEED_OSC, asrc)
    env.drive(8, 0);
    apb(1, `OFS_SYSTEM_CLOCK_CONTROL, 32'h0301, r);
    env.drive(8, 1);
    apb(0, `OFS_SYSTEM_CLOCK_CONTROL, 0, r);
    `CHK("no reload", 32'h0301, r)
    `CHK("low speed src", `SRC_LOW_SPEED_OSC, asrc)
    report_and_stop;
  end
endmodule // tb_top
